// [rtl/afi_pkg.sv]
// constants for the converter fifo and input interrupt logic
package afi_pkg;
	// register addresses on the serial register bus
	localparam logic [7:0] ADDR_FIFO_CTRL = 8'h15;
	localparam logic [7:0] ADDR_IN_EN     = 8'h16;
	localparam logic [7:0] ADDR_STATUS    = 8'h17;
	// fifo control field positions
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int CTRL_LVL_LSB   = 1;
	localparam int CTRL_OVW_BIT   = 6;
	// input enable field positions
	localparam int EN_CH_LSB = 0;
	localparam int EN_RDY_BIT = 7;
	// status field positions
	localparam int STAT_CH_LSB  = 0;
	localparam int STAT_LVL_LSB = 9;
	localparam int STAT_OVW_BIT = 14;
	// widths and counts
	localparam int NUM_CH     = 6;
	localparam int NUM_LVL    = 5;
	localparam int FIFO_DEPTH = 64;
	localparam int LEVEL_W    = 7;
	localparam int REG_W      = 8;
	localparam int STAT_W     = 16;
	// reset values
	localparam logic [REG_W-1:0]  CTRL_RESET  = 8'h00;
	localparam logic [REG_W-1:0]  IN_EN_RESET = 8'h00;
	localparam logic [STAT_W-1:0] RDATA_IDLE  = 16'h0000;
	// fill thresholds in eighths of the depth: 1, 2, 4, 6, 7
	localparam int LVL_EIGHTHS [NUM_LVL] = '{1, 2, 4, 6, 7};
endpackage

// [rtl/afi_irq_logic.sv]
// fifo clear, input interrupt enables and interrupt status of the converter
// What this block does
// R1 - writing one to clear bit empties fifo
// R2 - channel enable bits allow out-of-range interrupts
// R3 - channel flags set on event, clear on read
// R4 - fifo level flags track usage, never latched
// R5 - level flag drops when usage falls below
// R6 - level flags at 1/8,2/8,4/8,6/8,7/8 full
// R7 - overwrite flag sets when unread data lost
// R8 - interrupt pin asserts on enabled fifo condition
`timescale 1ns/100ps
module afi_irq_logic
	import afi_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)
(
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	input  wire logic [7:0]           reg_addr_in,
	input  wire logic [REG_W-1:0]     reg_wdata_in,
	input  wire logic [LEVEL_W-1:0]   fifo_level_in,
	input  wire logic                 fifo_overwrite_in,
	input  wire logic [NUM_CH-1:0]    channel_out_of_range_in,
	output logic [STAT_W-1:0]         reg_rdata_out,
	output logic                      fifo_clear_out,
	output logic                      data_ready_irq_enable_out,
	output logic                      irq_out
);

	logic [REG_W-1:0]   ctrl_q, ctrl_d;
	logic [REG_W-1:0]   in_en_q, in_en_d;
	logic [NUM_CH-1:0]  channel_out_of_range_bits_q, channel_out_of_range_bits_d;
	logic [NUM_LVL-1:0] lvl_q, lvl_d;
	logic               ovw_q, ovw_d;
	logic               clear_q, clear_d;
	logic               irq_q, irq_d;
	logic [STAT_W-1:0]  rdata_q, rdata_d;
	logic               wr_ctrl, wr_en, rd_stat;
	logic [STAT_W-1:0]  status_word;
	logic [NUM_CH-1:0]  chan_hit;

	// decoded strobes, one register per address
	assign wr_ctrl = reg_wr_in && (reg_addr_in == ADDR_FIFO_CTRL);
	assign wr_en   = reg_wr_in && (reg_addr_in == ADDR_IN_EN);
	assign rd_stat = reg_rd_in && (reg_addr_in == ADDR_STATUS);

	// status image as the host sees it; reserved bits read zero
	always_comb
	begin
		status_word = RDATA_IDLE;
		status_word[STAT_CH_LSB +: NUM_CH] = channel_out_of_range_bits_q;
		status_word[STAT_LVL_LSB +: NUM_LVL] = lvl_q;
		status_word[STAT_OVW_BIT] = ovw_q;
	end

	// next state of registers, flags and pins
	always_comb
	begin
		ctrl_d  = ctrl_q;
		in_en_d = in_en_q;
		clear_d = 1'h0;
		if (wr_ctrl)
		begin
			ctrl_d = reg_wdata_in;
			ctrl_d[CTRL_CLEAR_BIT] = 1'h0; // clear is a pulse, reads back zero
			clear_d = reg_wdata_in[CTRL_CLEAR_BIT]; // R1
		end
		if (wr_en)
			in_en_d = reg_wdata_in;
		// a new event in the read cycle survives the clear
		channel_out_of_range_bits_d = rd_stat ? '0 : channel_out_of_range_bits_q; // R3
		channel_out_of_range_bits_d = channel_out_of_range_bits_d
			| (channel_out_of_range_in & in_en_q[EN_CH_LSB +: NUM_CH]); // R2 R3
		// level flags are pure compares, recomputed every cycle
		for (int i = 0; i < NUM_LVL; i++)
			lvl_d[i] = (int'(fifo_level_in) * 8 >= LVL_EIGHTHS[i] * DEPTH); // R4 R5 R6
		// overwrite holds only while the fifo stays full
		ovw_d = fifo_overwrite_in
			|| (ovw_q && (int'(fifo_level_in) >= DEPTH) && !clear_q); // R7
		irq_d = (|(lvl_d & ctrl_d[CTRL_LVL_LSB +: NUM_LVL]))
			|| (ovw_d && ctrl_d[CTRL_OVW_BIT])
			|| (|channel_out_of_range_bits_d); // R8 R2
		rdata_d = RDATA_IDLE;
		if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				ADDR_FIFO_CTRL: rdata_d = {8'h00, ctrl_q};
				ADDR_IN_EN:     rdata_d = {8'h00, in_en_q};
				ADDR_STATUS:    rdata_d = status_word;
				default:        rdata_d = RDATA_IDLE; // unmapped reads zero
			endcase
		end
	end

	// register stage
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			ctrl_q  <= CTRL_RESET;
			in_en_q <= IN_EN_RESET;
			channel_out_of_range_bits_q <= '0;
			lvl_q   <= '0;
			ovw_q   <= 1'h0;
			clear_q <= 1'h0;
			irq_q   <= 1'h0;
			rdata_q <= RDATA_IDLE;
		end
		else
		begin
			ctrl_q  <= ctrl_d;
			in_en_q <= in_en_d;
			channel_out_of_range_bits_q <= channel_out_of_range_bits_d;
			lvl_q   <= lvl_d;
			ovw_q   <= ovw_d;
			clear_q <= clear_d;
			irq_q   <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	// every output comes straight from a flop
	assign reg_rdata_out = rdata_q;
	assign fifo_clear_out = clear_q;
	assign data_ready_irq_enable_out = in_en_q[EN_RDY_BIT];
	assign irq_out = irq_q;

	// checks
	property p_clear;
		@(posedge clk_in) disable iff (!rst_n_in)
		(wr_ctrl && reg_wdata_in[CTRL_CLEAR_BIT])
			|=> fifo_clear_out && !ctrl_q[CTRL_CLEAR_BIT];
	endproperty
	a_clear: assert property (p_clear) else $error("fifo clear pulse missing"); // R1

	// back-to-back clears are legal, so the pulse is checked against its cause
	property p_clear_once;
		@(posedge clk_in) disable iff (!rst_n_in)
		fifo_clear_out |-> $past(wr_ctrl && reg_wdata_in[CTRL_CLEAR_BIT]);
	endproperty
	a_clear_once: assert property (p_clear_once) else $error("stray fifo clear pulse"); // R1

	property p_masked;
		@(posedge clk_in) disable iff (!rst_n_in)
		(channel_out_of_range_bits_q == '0 && rd_stat == 1'h0
			&& (channel_out_of_range_in & in_en_q[EN_CH_LSB +: NUM_CH]) == '0)
			|=> channel_out_of_range_bits_q == '0;
	endproperty
	a_masked: assert property (p_masked) else $error("disabled channel set a flag"); // R2

	property p_irq_chan;
		@(posedge clk_in) disable iff (!rst_n_in)
		(channel_out_of_range_bits_q != '0) |-> irq_out;
	endproperty
	a_irq_chan: assert property (p_irq_chan) else $error("channel flag without interrupt"); // R2

	property p_rd_clear;
		@(posedge clk_in) disable iff (!rst_n_in)
		(rd_stat && channel_out_of_range_in == '0) |=> channel_out_of_range_bits_q == '0;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("status read left flags"); // R3

	// enabled events, watched by the set-wins check
	assign chan_hit = channel_out_of_range_in & in_en_q[EN_CH_LSB +: NUM_CH];

	property p_set_wins;
		@(posedge clk_in) disable iff (!rst_n_in)
		(chan_hit != '0)
			|=> ((channel_out_of_range_bits_q & $past(chan_hit)) == $past(chan_hit));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("channel event lost"); // R3

	property p_stat_rsvd;
		@(posedge clk_in) disable iff (!rst_n_in)
		rd_stat |=> (reg_rdata_out[STAT_W-1] == 1'h0);
	endproperty
	a_stat_rsvd: assert property (p_stat_rsvd) else $error("reserved status bit set"); // R6

	property p_stable_lvl;
		@(posedge clk_in) disable iff (!rst_n_in)
		(rd_stat && $stable(fifo_level_in)) |=> $stable(lvl_q);
	endproperty
	a_stable_lvl: assert property (p_stable_lvl) else $error("read disturbed levels"); // R4

	// half flag alias read by the drop check
	logic reg_rdata_q_half;
	assign reg_rdata_q_half = lvl_q[2];

	property p_drop;
		@(posedge clk_in) disable iff (!rst_n_in)
		(int'(fifo_level_in) * 2 < DEPTH) |=> !reg_rdata_q_half;
	endproperty
	a_drop: assert property (p_drop) else $error("half flag stuck"); // R5

	property p_drop_eighth;
		@(posedge clk_in) disable iff (!rst_n_in)
		(int'(fifo_level_in) * 8 < DEPTH) |=> !lvl_q[0];
	endproperty
	a_drop_eighth: assert property (p_drop_eighth) else $error("eighth flag stuck"); // R5

	property p_eighth;
		@(posedge clk_in) disable iff (!rst_n_in)
		(int'(fifo_level_in) * 8 >= DEPTH) |=> lvl_q[0];
	endproperty
	a_eighth: assert property (p_eighth) else $error("eighth flag missing"); // R6

	property p_lvl_full;
		@(posedge clk_in) disable iff (!rst_n_in)
		(int'(fifo_level_in) * 8 >= LVL_EIGHTHS[NUM_LVL-1] * DEPTH) |=> lvl_q[NUM_LVL-1];
	endproperty
	a_lvl_full: assert property (p_lvl_full) else $error("top level flag missing"); // R6

	property p_ovw;
		@(posedge clk_in) disable iff (!rst_n_in)
		fifo_overwrite_in |=> ovw_q;
	endproperty
	a_ovw: assert property (p_ovw) else $error("overwrite flag missing"); // R7

	property p_ovw_clear;
		@(posedge clk_in) disable iff (!rst_n_in)
		(fifo_clear_out && !fifo_overwrite_in) |=> !ovw_q;
	endproperty
	a_ovw_clear: assert property (p_ovw_clear) else $error("overwrite flag survived clear"); // R7

	property p_irq;
		@(posedge clk_in) disable iff (!rst_n_in)
		(|(lvl_q & ctrl_q[CTRL_LVL_LSB +: NUM_LVL])) |-> irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt pin not asserted"); // R8

	// no enabled condition means a quiet pin
	property p_irq_off;
		@(posedge clk_in) disable iff (!rst_n_in)
		((lvl_q & ctrl_q[CTRL_LVL_LSB +: NUM_LVL]) == '0
			&& !(ovw_q && ctrl_q[CTRL_OVW_BIT])
			&& channel_out_of_range_bits_q == '0) |-> !irq_out;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("spurious interrupt"); // R8

endmodule

// [tb/afi_fifo_model.sv]
// fifo occupancy model standing in for the converter storage
`timescale 1ns/100ps
module afi_fifo_model
#(
	parameter int DEPTH = 16
)
(
	input  wire logic  clk_in,
	input  wire logic  rst_n_in,
	input  wire logic  clear_in,
	input  wire logic  push_in,
	output logic [6:0] level_out,
	output logic       overwrite_out
);
	// a full fifo keeps its count, so a push there overwrites
	always_ff @(posedge clk_in)
	begin
		overwrite_out <= rst_n_in && push_in && level_out == DEPTH;
		if (!rst_n_in || clear_in)
			level_out <= 7'h00;
		else if (push_in && level_out < DEPTH)
			level_out <= level_out + 7'h01;
	end
endmodule

// [tb/afi_irq_logic_tb.sv]
// self-checking bench for the fifo and input interrupt logic
`timescale 1ns/100ps
module afi_irq_logic_tb;
	import afi_pkg::*;
	localparam int DEPTH = 16;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        push = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic [5:0]  oor = 6'h00;
	logic [6:0]  level;
	logic [15:0] rdata;
	logic [15:0] exp_st;
	logic        ovw, clr, rdy_en, irq;
	int          failures = 0;
	int          comparisons = 0;
	// short depth keeps the fill loop brief
	afi_irq_logic #(.DEPTH(DEPTH)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.fifo_level_in(level), .fifo_overwrite_in(ovw), .channel_out_of_range_in(oor),
		.reg_rdata_out(rdata), .fifo_clear_out(clr), .data_ready_irq_enable_out(rdy_en),
		.irq_out(irq));
	afi_fifo_model #(.DEPTH(DEPTH)) model (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.clear_in(clr), .push_in(push), .level_out(level), .overwrite_out(ovw));
	always #2 clk_in = ~clk_in;
	task automatic compare(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one strobe cycle, driven between rising edges
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		wr = w;
		rd = !w;
		addr = a;
		wdata = d;
		@(negedge clk_in);
		wr = 1'b0;
		rd = 1'b0;
	endtask
	task automatic read(input logic [7:0] a, input logic [15:0] exp);
		access(1'b0, a, 8'h00);
		compare("read data", exp, rdata);
	endtask
	task automatic complete_run();
		if (failures == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// about 5000 cycles, many times what the tests need
	initial
	begin
		#20000;
		failures++;
		complete_run();
	end
	initial
	begin
		repeat (10) @(negedge clk_in);
		rst_n_in = 1'b1;
		read(ADDR_STATUS, 16'h0000);
		access(1'b1, ADDR_IN_EN, 8'hBD);
		read(ADDR_IN_EN, 16'h00BD);
		compare("ready enable", 16'h0001, {15'h0, rdy_en});
		oor = 6'h3F;
		@(negedge clk_in);
		oor = 6'h00;
		@(negedge clk_in);
		compare("irq", 16'h0001, {15'h0, irq});
		read(8'h20, 16'h0000);
		read(ADDR_STATUS, 16'h003D);
		read(ADDR_STATUS, 16'h0000);
		// a disabled channel and a write to status must leave no flag
		access(1'h1, ADDR_STATUS, 8'h3F);
		oor = 6'h02;
		@(negedge clk_in);
		oor = 6'h00;
		read(ADDR_STATUS, 16'h0000);
		// an event in the read cycle survives that read
		fork
			read(ADDR_STATUS, 16'h0000);
			begin
				@(negedge clk_in);
				oor = 6'h01;
				@(negedge clk_in);
				oor = 6'h00;
			end
		join
		read(ADDR_STATUS, 16'h0001);
		access(1'b1, ADDR_FIFO_CTRL, 8'h04);
		// last push lands on a full fifo
		for (int n = 1; n <= DEPTH + 1; n++)
		begin
			push = 1'b1;
			@(negedge clk_in);
			push = 1'b0;
			@(negedge clk_in);
			exp_st = (n > DEPTH) ? 16'h4000 : 16'h0000;
			for (int i = 0; i < NUM_LVL; i++)
				exp_st[STAT_LVL_LSB + i] = (n * 8 >= LVL_EIGHTHS[i] * DEPTH);
			compare("irq", {15'h0, exp_st[10]}, {15'h0, irq});
			read(ADDR_STATUS, exp_st);
		end
		access(1'b1, ADDR_FIFO_CTRL, 8'h40);
		@(negedge clk_in);
		compare("irq", 16'h0001, {15'h0, irq});
		access(1'b1, ADDR_FIFO_CTRL, 8'h45);
		compare("clear pulse", 16'h0001, {15'h0, clr});
		repeat (2) @(negedge clk_in);
		read(ADDR_STATUS, 16'h0000);
		read(ADDR_FIFO_CTRL, 16'h0044);
		compare("irq", 16'h0000, {15'h0, irq});
		// reset in mid-run must bring the fifo control and input enable registers back to zero
		rst_n_in = 1'h0;
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'h1;
		read(ADDR_FIFO_CTRL, 16'h0000);
		read(ADDR_IN_EN, 16'h0000);
		compare("ready enable", 16'h0000, {15'h0, rdy_en});
		complete_run();
	end
endmodule
